//--- csd_pkg.sv
// Package for the clock synthesizer divider control block.
// Assumes a single 100 MHz system clock; all counts derive from it.
`default_nettype none
package csd_pkg;
  // ----------------------------------------
  // Control word layout
  // ----------------------------------------
  localparam int unsigned CSD_HALF_BIT = 15;
  localparam int unsigned CSD_MUL_LSB = 12;
  localparam int unsigned CSD_TAP_LSB = 8;
  localparam logic [2:0] CSD_MUL_RESET = 3'h3;
  localparam logic [2:0] CSD_TAP_RESET = 3'h0;
  localparam logic CSD_HALF_RESET_FAST = 1'h0;
  localparam logic CSD_HALF_RESET_EXT = 1'h1;
  localparam logic [2:0] CSD_TAP_MAX = 3'h6;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CSD_CLK_MHZ = 100;
  localparam int unsigned CSD_LOCK_TIME_US = 200;
  localparam int unsigned CSD_LOCK_CYCLES = CSD_LOCK_TIME_US * CSD_CLK_MHZ;

  typedef enum logic [1:0] {
    CSD_MODE_FAST = 2'b00,
    CSD_MODE_EXT = 2'b01
  } csd_mode_t;

  // Write request for the frequency control word
  typedef struct packed {
    logic wr;
    logic [15:0] data;
  } csd_wr_t;
endpackage
`default_nettype wire

//--- csd_toggle_div.sv
// One divide-by-two stage with a 50% duty output.
// Assumes an enable pulse train at twice the output rate.
`default_nettype none
module csd_toggle_div (
  input wire logic clock_i, // System clock
  input wire logic rst_n_i, // Synchronised reset, active low
  input wire logic en_i,    // Input edge pulse
  output logic q_o,         // Halved output level
  output logic pulse_o      // Pulse when output falls
);
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= 1'b0;
    end else if (en_i) begin
      q_o <= ~q_o;
    end
  end
  // Falling output edge clocks the next stage
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= en_i & q_o;
    end
  end
endmodule
`default_nettype wire

//--- csd_lock_timer.sv
// Lock timer: holds lock low for a fixed count after a restart.
// Assumes restart is a one-cycle pulse.
`default_nettype none
module csd_lock_timer #(
  parameter int unsigned CYCLES = csd_pkg::CSD_LOCK_CYCLES
) (
  input wire logic clock_i,   // System clock
  input wire logic rst_n_i,   // Synchronised reset, active low
  input wire logic restart_i, // Start a new lock period
  output logic locked_o       // Timer expired
);
  import csd_pkg::*;
  logic [31:0] count;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count <= 32'h0;
    end else if (restart_i) begin
      count <= CYCLES[31:0];
    end else if (count != 32'h0) begin
      count <= count - 32'h1;
    end
  end
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      locked_o <= 1'b0;
    end else begin
      locked_o <= !restart_i && (count <= 32'h1);
    end
  end
endmodule
`default_nettype wire

//--- csd_clock_synth.sv
// What this block does
// RULE_01 - Fast mode reset gives twice reference
// RULE_02 - Multiplier field gives value plus one
// RULE_03 - Multiplier resets to binary 11
// RULE_04 - Multiplier write drops lock for lock time
// RULE_05 - Halving bit clear divides, set bypasses
// RULE_06 - Tap divides by two to field
// RULE_07 - Fast mode tap seven acts six
// RULE_08 - Halving or tap changes keep lock
// RULE_09 - Tap field resets to zero
// RULE_10 - System clock has 50% duty
// RULE_11 - Software avoids over-frequency settings
// RULE_12 - Slow mode VCO four or two times; no slow mode is modelled here
// RULE_13 - External mode VCO off, input divided
// RULE_14 - External mode divides up to 128
// RULE_15 - External reset: halving one, tap zero
// RULE_16 - External tap seven acts six, immediate
// RULE_17 - External mode ignores multiplier writes
// RULE_18 - Word bits 15, 14:12, 10:8
// RULE_19 - Lock flag low only while relocking
// RULE_20 - Fast clock equals reference times factor
//
// Top of the clock synthesizer frequency control.
// Assumes the reference and external inputs arrive as one-cycle edge
// pulses in the system clock domain; the VCO is modelled by a pulse
// multiplier, so reference rates must stay well under 100 MHz / 16.
`default_nettype none
module csd_clock_synth #(
  parameter int unsigned LOCK_CYCLES = csd_pkg::CSD_LOCK_CYCLES,
  parameter int unsigned REF_PERIOD_MAX = 256
) (
  input wire logic clock_i,                      // 100 MHz system clock
  input wire logic rst_n_i,                      // Async reset, active low
  input wire logic ext_mode_i,                   // Mode strap, high for external
  input wire logic ref_edge_i,                   // Reference rising edge pulse
  input wire logic external_clock_input_pin_i,   // External clock edge pulse
  input wire csd_pkg::csd_wr_t ctl_wr_i,         // Control word write
  output logic [15:0] synthesizer_control_word_o, // Control word readback
  output logic pll_lock_flag_o,                  // Lock status
  output logic vco_on_o,                         // VCO running
  output logic system_clock_output_o             // System clock level
);
  import csd_pkg::*;

  // ----------------------------------------
  // Reset synchroniser
  // ----------------------------------------
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  // ----------------------------------------
  // Mode strap
  // ----------------------------------------
  // Strap caught on the first cycle after release, then held
  csd_mode_t mode;
  logic strap_done;
  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      strap_done <= 1'b0;
    end else begin
      strap_done <= 1'b1;
    end
  end
  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      mode <= CSD_MODE_FAST;
    end else if (!strap_done) begin
      mode <= ext_mode_i ? CSD_MODE_EXT : CSD_MODE_FAST;
    end
  end
  // A pin change after the strap cycle is ignored until the next reset
  logic is_ext;
  assign is_ext = (mode == CSD_MODE_EXT);

  // ----------------------------------------
  // Control fields
  // ----------------------------------------
  logic half_bypass;
  logic [2:0] mul;
  logic [2:0] tap;
  logic mul_written;

  // RULE_05 RULE_15 halving reset value
  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      half_bypass <= CSD_HALF_RESET_FAST;
    end else if (!strap_done) begin
      half_bypass <= ext_mode_i ? CSD_HALF_RESET_EXT : CSD_HALF_RESET_FAST;
    end else if (ctl_wr_i.wr) begin
      half_bypass <= ctl_wr_i.data[CSD_HALF_BIT];
    end
  end

  // RULE_09 RULE_18 tap field
  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      tap <= CSD_TAP_RESET;
    end else if (ctl_wr_i.wr && strap_done) begin
      tap <= ctl_wr_i.data[CSD_TAP_LSB +: 3];
    end
  end

  // RULE_03 RULE_17 multiplier, frozen in external mode
  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      mul <= CSD_MUL_RESET;
    end else if (ctl_wr_i.wr && strap_done && !is_ext) begin
      mul <= ctl_wr_i.data[CSD_MUL_LSB +: 3];
    end
  end

  // RULE_04 relock only when the value really changes
  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      mul_written <= 1'b0;
    end else begin
      mul_written <= ctl_wr_i.wr && strap_done && !is_ext &&
        (ctl_wr_i.data[CSD_MUL_LSB +: 3] != mul);
    end
  end

  // RULE_18 readback; unused bits in external mode read zero
  logic [15:0] next_word;
  always_comb begin
    next_word = 16'h0000;
    next_word[CSD_HALF_BIT] = half_bypass;
    next_word[CSD_MUL_LSB +: 3] = is_ext ? 3'h0 : mul;
    next_word[CSD_TAP_LSB +: 3] = tap;
  end
  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      synthesizer_control_word_o <= 16'h0;
    end else begin
      synthesizer_control_word_o <= next_word;
    end
  end

  // ----------------------------------------
  // Lock tracking
  // ----------------------------------------
  logic lock_done;
  logic lock_restart;
  // RULE_04 lock lost after power-up or multiplier change
  assign lock_restart = mul_written || (strap_done == 1'b0 && rst_sync);
  csd_lock_timer #(
    .CYCLES(LOCK_CYCLES)
  ) u_lock (
    .clock_i(clock_i),
    .rst_n_i(rst_sync),
    .restart_i(lock_restart),
    .locked_o(lock_done)
  );

  // RULE_19 RULE_08 bypassed PLL reads locked
  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      pll_lock_flag_o <= 1'b0;
    end else begin
      pll_lock_flag_o <= is_ext ? 1'b1 : lock_done;
    end
  end

  // ----------------------------------------
  // VCO enable
  // ----------------------------------------
  // RULE_13 VCO off in external mode
  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      vco_on_o <= 1'b0;
    end else begin
      vco_on_o <= strap_done && !is_ext;
    end
  end

  // ----------------------------------------
  // Period measurement of the reference or external input
  // ----------------------------------------
  // RULE_13 external input takes the place of the reference
  logic meas_edge;
  assign meas_edge = is_ext ? external_clock_input_pin_i : ref_edge_i;
  // Edge train runs in fast mode, and without the VCO in external mode
  logic src_run;
  assign src_run = vco_on_o || (strap_done && is_ext);

  logic [15:0] ref_count;
  logic [15:0] ref_period;
  logic meas_seen;

  // Cycles since the last input edge, saturating
  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      ref_count <= 16'h0;
    end else if (meas_edge) begin
      ref_count <= 16'h1;
    end else if (ref_count != 16'(REF_PERIOD_MAX)) begin
      ref_count <= ref_count + 16'h1;
    end
  end

  // First edge only starts the count: the span since reset is no period
  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      meas_seen <= 1'b0;
    end else if (meas_edge) begin
      meas_seen <= 1'b1;
    end
  end

  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      ref_period <= 16'h0;
    end else if (meas_edge && meas_seen) begin
      ref_period <= ref_count;
    end
  end

  // ----------------------------------------
  // Edge multiplier: VCO in fast mode, doubler in external mode
  // ----------------------------------------
  // RULE_02 RULE_20 two edges per input period per unit of factor
  logic [3:0] factor;
  logic [15:0] vco_inc;
  logic [15:0] vco_sum;
  logic [15:0] vco_acc;
  logic vco_edge;
  // RULE_17 multiplier has no say in external mode
  assign factor = is_ext ? 4'h1 : ({1'b0, mul} + 4'h1);
  assign vco_inc = {11'h0, factor, 1'b0};
  assign vco_sum = vco_acc + vco_inc;

  // Phase accumulator: the edge count per period is exact and the spacing
  // only alternates by one cycle, which keeps the output duty near half.
  // A period shorter than twice the factor loses edges.
  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      vco_acc <= 16'h0;
    end else if (!src_run || ref_period == 16'h0) begin
      vco_acc <= 16'h0;
    end else if (vco_sum >= ref_period) begin
      vco_acc <= vco_sum - ref_period;
    end else begin
      vco_acc <= vco_sum;
    end
  end

  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      vco_edge <= 1'b0;
    end else begin
      vco_edge <= src_run && (ref_period != 16'h0) && (vco_sum >= ref_period);
    end
  end

  // ----------------------------------------
  // Output path: halving stage then six-stage tap chain
  // ----------------------------------------
  // RULE_13 RULE_15 one edge per half period of the source, either mode
  logic src_edge;
  assign src_edge = vco_edge;

  // RULE_05 RULE_01 halving stage
  logic half_q;
  logic half_pulse;
  csd_toggle_div u_half (
    .clock_i(clock_i),
    .rst_n_i(rst_sync),
    .en_i(src_edge),
    .q_o(half_q),
    .pulse_o(half_pulse)
  );
  logic stage0_edge;
  // Halved path toggles once per two source edges
  assign stage0_edge = half_bypass ? src_edge : (src_edge & half_q);

  // RULE_06 RULE_14 chain of six halving stages
  logic [6:0] chain_edge;
  logic [5:0] chain_q;
  assign chain_edge[0] = stage0_edge;
  genvar gi;
  generate
    for (gi = 0; gi < 6; gi++) begin : g_chain
      csd_toggle_div u_stage (
        .clock_i(clock_i),
        .rst_n_i(rst_sync),
        .en_i(chain_edge[gi]),
        .q_o(chain_q[gi]),
        .pulse_o()
      );
      assign chain_edge[gi+1] = chain_edge[gi] & chain_q[gi];
    end
  endgenerate

  // ----------------------------------------
  // Tap select
  // ----------------------------------------
  // RULE_07 RULE_16 tap seven saturates at six
  logic [2:0] tap_eff;
  assign tap_eff = (tap > CSD_TAP_MAX) ? CSD_TAP_MAX : tap;
  // Tap switches at once; a stage mid-count only shifts the phase
  logic tap_edge;
  always_comb begin
    tap_edge = chain_edge[6];
    case (tap_eff)
      3'h0: tap_edge = chain_edge[0];
      3'h1: tap_edge = chain_edge[1];
      3'h2: tap_edge = chain_edge[2];
      3'h3: tap_edge = chain_edge[3];
      3'h4: tap_edge = chain_edge[4];
      3'h5: tap_edge = chain_edge[5];
      3'h6: tap_edge = chain_edge[6];
      default: tap_edge = chain_edge[6];
    endcase
  end

  // ----------------------------------------
  // Output toggle
  // ----------------------------------------
  // RULE_10 RULE_08 output toggles on selected tap edge, 50% duty
  always_ff @(posedge clock_i or negedge rst_sync) begin
    if (!rst_sync) begin
      system_clock_output_o <= 1'b0;
    end else if (tap_edge) begin
      system_clock_output_o <= ~system_clock_output_o;
    end
  end

  // RULE_12 slow reference mode not modelled; no slow path exists here
  // RULE_11 unsupported settings are the programmer's to avoid
  logic unused_ok;
  assign unused_ok = half_pulse;
endmodule
`default_nettype wire

//--- csd_pulse_src.sv
// Free running edge pulse source for the reference or external input.
// Assumes the bench clock; pulses change 1 ns after the edge.
`default_nettype none
module csd_pulse_src #(
  parameter int unsigned PERIOD = 32
) (
  input wire logic clock_i, // System clock
  output logic pulse_o      // One-cycle edge pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt = 0;
  initial pulse_o = 1'b0;
  always @(posedge clock_i) begin
    #1;
    cnt = (cnt + 1) % PERIOD;
    pulse_o = (cnt == 0);
  end
endmodule
`default_nettype wire

//--- csd_clock_synth_monitor.sv
// Port checker for the clock synthesizer control block.
// Assumes one clock and writes spaced by three cycles or more.
`default_nettype none
module csd_clock_synth_monitor #(
  parameter int unsigned LOCK_CYCLES = 20
) (
  input wire logic clock_i,                   // System clock
  input wire logic rst_n_i,                   // Reset, active low
  input wire logic ext_mode_i,                // Mode strap
  input wire csd_pkg::csd_wr_t ctl_wr_i,      // Control word write
  input wire logic [15:0] synthesizer_control_word_o, // Readback
  input wire logic pll_lock_flag_o,           // Lock status
  input wire logic vco_on_o                   // VCO running
);
  import csd_pkg::*;
  wire [15:0] rb = synthesizer_control_word_o;
  wire [15:0] d = ctl_wr_i.data;
  wire wr = ctl_wr_i.wr;
  wire lk = pll_lock_flag_o;
  logic [15:0] low_cnt;
  // Saturates so a stuck flag cannot wrap
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt <= 16'h0000;
    end else if (lk) begin
      low_cnt <= 16'h0000;
    end else if (low_cnt != 16'hFFFF) begin
      low_cnt <= low_cnt + 16'h0001;
    end
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  sequence s_relock; ##[1:3] !lk; endsequence
  sequence s_hold; lk [*4]; endsequence
  AST_RB_XY: assert property (
    wr |-> ##2 rb[15] == $past(d[15], 2) && rb[10:8] == $past(d[10:8], 2))
    else $error("X or Y readback wrong");
  AST_RB_W: assert property (
    wr && vco_on_o |-> ##2 rb[14:12] == $past(d[14:12], 2)) else $error("W readback wrong");
  AST_RB_ZERO: assert property (
    rb[11] == 1'b0 && rb[7:0] == 8'h00) else $error("unused bits set");
  AST_EXT_W: assert property (
    !vco_on_o && lk |-> rb[14:12] == 3'h0) else $error("W live in external mode");
  AST_EXT_VCO: assert property (
    ext_mode_i && lk |-> !vco_on_o) else $error("VCO on in external mode");
  AST_BYPASS_LOCK: assert property (
    $fell(lk) |-> vco_on_o) else $error("lock fell with VCO off");
  AST_RELOCK: assert property (
    wr && vco_on_o && lk && d[14:12] != rb[14:12] |-> s_relock) else $error("no relock");
  AST_KEEP: assert property (
    wr && vco_on_o && lk && d[14:12] == rb[14:12] |-> ##1 s_hold) else $error("lock lost");
  AST_LOCK_LEN: assert property (
    $rose(lk) && vco_on_o |-> low_cnt >= LOCK_CYCLES - 1 && low_cnt <= LOCK_CYCLES + 8)
    else $error("lock time wrong");
endmodule
bind csd_clock_synth csd_clock_synth_monitor #(.LOCK_CYCLES(LOCK_CYCLES)) u_mon (
  .clock_i(clock_i), .rst_n_i(rst_n_i), .ext_mode_i(ext_mode_i), .ctl_wr_i(ctl_wr_i),
  .synthesizer_control_word_o(synthesizer_control_word_o),
  .pll_lock_flag_o(pll_lock_flag_o), .vco_on_o(vco_on_o));
`default_nettype wire

//--- clock_synth_divider_control_tb.sv
// Self-checking bench for the clock synthesizer control block.
// Assumes pulse sources of 32 and 16 cycles; lock time cut to 20.
`default_nettype none
module clock_synth_divider_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import csd_pkg::*;
  localparam int WIN = 4096;
  logic clock_i = 1'b0;
  logic rst_n = 1'b0;
  logic ext_mode = 1'b0;
  csd_wr_t ctl_wr = '0;
  logic ref_edge, ext_edge, lock, vco_on, sys_clk;
  logic [15:0] rb;
  int errors = 0;
  int num_checks = 0;
  `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin errors++; \
    $display("BAD %0t mismatch", $time); end end
  initial forever #5 clock_i = ~clock_i;
  csd_pulse_src #(.PERIOD(32)) u_ref (.clock_i(clock_i), .pulse_o(ref_edge));
  csd_pulse_src #(.PERIOD(16)) u_ext (.clock_i(clock_i), .pulse_o(ext_edge));
  csd_clock_synth #(.LOCK_CYCLES(20), .REF_PERIOD_MAX(256)) uut (.clock_i(clock_i),
    .rst_n_i(rst_n), .ext_mode_i(ext_mode), .ref_edge_i(ref_edge),
    .external_clock_input_pin_i(ext_edge), .ctl_wr_i(ctl_wr),
    .synthesizer_control_word_o(rb), .pll_lock_flag_o(lock), .vco_on_o(vco_on),
    .system_clock_output_o(sys_clk));
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask
  task automatic wait_lock();
    int n;
    n = 0;
    while (lock !== 1'b1 && n < 200) begin
      tick(1);
      n++;
    end
    if (n >= 200) begin
      errors++;
      $display("BAD %0t lock timeout", $time);
      complete_run();
    end
  endtask
  task automatic do_reset(input logic e);
    rst_n = 1'b0;
    ext_mode = e;
    tick(8);
    rst_n = 1'b1;
    tick(6);
  endtask
  task automatic write_word(input logic [15:0] d);
    tick(1);
    ctl_wr = '{wr: 1'b1, data: d};
    tick(1);
    ctl_wr.wr = 1'b0;
    tick(3);
  endtask
  // Rising edges of the system clock expected in WIN cycles
  function automatic int exp_rises(input logic e, input logic [15:0] d);
    int m;
    int ym;
    // External pulses come at twice the reference rate
    m = e ? 2 : int'(d[14:12]) + 1;
    ym = (d[10:8] == 3'h7) ? 6 : int'(d[10:8]);
    return (m * (64 << d[15])) >> ym;
  endfunction
  // One rise of slack: window phase against the divider is unknown
  task automatic measure(input logic e, input logic [15:0] d);
    int r;
    int hi;
    int ex;
    logic last;
    // Period measurement needs two input edges after a reset
    tick(64);
    r = 0;
    hi = 0;
    last = sys_clk;
    ex = exp_rises(e, d);
    repeat (WIN) begin
      tick(1);
      hi += (sys_clk === 1'b1);
      r += (sys_clk === 1'b1 && last === 1'b0);
      last = sys_clk;
    end
    `CHK(r >= ex - 1 && r <= ex + 1, 1'b1)
    if (!e && ex >= 16) begin
      `CHK(hi * 8 >= WIN * 3 && hi * 8 <= WIN * 5, 1'b1)
    end
  endtask
  initial begin
    logic [15:0] d;
    logic [2:0] w_old;
    void'($urandom(60061));
    do_reset(1'b0);
    `CHK(rb, 16'h3000)
    `CHK(lock, 1'b0)
    wait_lock();
    `CHK(vco_on, 1'b1)
    measure(1'b0, 16'h3000);
    for (int i = 0; i < 10; i++) begin
      d = $urandom();
      if (i == 0) d[15:8] = 8'hF7;
      if (i == 1) d[15:8] = {1'b0, rb[14:12], 1'b1, 3'h6};
      if (i == 2) d[15:8] = 8'h00;
      w_old = rb[14:12];
      write_word(d);
      `CHK(rb, {d[15:12], 1'b0, d[10:8], 8'h00})
      if (d[14:12] != w_old) begin
        `CHK(lock, 1'b0)
        wait_lock();
      end else begin
        `CHK(lock, 1'b1)
      end
      measure(1'b0, d);
    end
    $display("test fast done");
    do_reset(1'b1);
    `CHK(rb, 16'h8000)
    `CHK({lock, vco_on}, 2'b10)
    measure(1'b1, 16'h8000);
    for (int i = 0; i < 6; i++) begin
      d = $urandom();
      if (i == 0) d[10:8] = 3'h7;
      write_word(d);
      `CHK(rb, {d[15], 4'h0, d[10:8], 8'h00})
      `CHK(lock, 1'b1)
      measure(1'b1, d);
    end
    $display("test ext done");
    complete_run();
  end
endmodule
`default_nettype wire
